// [rtl/dpll_mode_and_phase_detect.sv]
// Mode machine, freeze, bandwidth choice and phase capture of the main loop.
//
// Overview of operation
// R01: On selected input stop, freeze frequency within two input cycles, enter short freeze.
// R02: Short freeze frequency source comes from holdover config bits four to three.
// R03: Short freeze ends on new source, full holdover, or input fault clearing.
// R04: Holdover moves to reacquire state when a reference is selected and applied.
// R05: Revertive mode enters reacquire when a higher priority reference returns.
// R06: Reacquire lasts at most 100 seconds without lock unless software forces locked.
// R07: On timeout: disqualify reference, raise phase alarm, return to holdover, reselect.
// R08: Software must force locked mode when acquisition needs up to 700 seconds.
// R09: Core loop runs at 204.8 MHz from 12.8 MHz; edge resolution 4.9 ns. Here CLK_HZ is 20 MHz, so edges resolve to 50 ns.
// R10: Automatic bandwidth (bit 7) switches between pull-in and tracking bandwidths.
// R11: Without automatic bandwidth, tracking bandwidth serves both acquisition and lock.
// R12: Separate pull-in and tracking bandwidths, 18 steps, 0.5 mHz to 70 Hz.
// R13: Damping factor chosen from 1.2, 2.5, 5, 10 or 20.
// R14: Detector takes up to 77.76 MHz; 155.52 MHz input is halved first.
// R15: Eight kilohertz lock bit six divides every input to 8 kHz first.
// R16: Nearest-edge capture after lock when multi-cycle detector is disabled.
// R17: Nearest-edge disable bit six keeps full 360 degree frequency capture.
// R18: Multi-cycle detector enabled by bit six; range field selects 2^(n+1)-1 UI.
// R19: Bit five feeds multi-cycle phase to loop; else loop term limited to 360.
// R20: Multi-cycle detector always tracks total phase difference regardless of loop use.
// R21: Auxiliary loop has one bandwidth: 18, 35 or 70 Hz.
// R22: Phase offset adjustable in 6 ps steps over plus or minus 200 ns.
// R23: Holdover averager time constant 8 or 110 minutes, value readable.
// R24: Locked only after detectors report continuous lock for one second.
// R25: Pull-in bandwidth while unlocked, tracking bandwidth once lock is indicated.
// R26: Lock-driven switching is synchronous and keeps the accumulated frequency.
`timescale 1ns/1ns
`default_nettype none

module dpll_mode_and_phase_detect #(
  parameter longint REACQ_CYCLES = loop_ctrl_pkg::REACQ_CYCLES,
  parameter longint LOCK_CYCLES  = loop_ctrl_pkg::LOCK_HOLD_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  input  wire logic        refClk,
  input  wire logic        fbClk,
  input  wire logic        refValid,
  input  wire logic        refSelected,
  input  wire logic        higherPrioValid,
  input  wire logic        phaseLockRaw,
  input  wire logic [18:0] loopFreqIn,
  output logic             miniHoldover,
  output logic      [2:0]  operatingMode,
  output logic             disqualify,
  output logic             phaseAlarm,
  output logic      [4:0]  activeBw,
  output logic      [2:0]  dampingSel,
  output logic      [1:0]  auxBwSel,
  output logic             nearestEdge,
  output logic      [23:0] loopPhase,
  output logic      [18:0] freezeFreq,
  output logic      [15:0] phaseOffset
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [4:0] clampBw(input logic [4:0] v);
    clampBw = (v < loop_ctrl_pkg::BW_STEPS) ? v : loop_ctrl_pkg::BW_STEPS - 5'h01;
  endfunction : clampBw

  function automatic logic [23:0] mcLimit(input logic [3:0] r);
    logic [4:0] sh;
    sh = (r > loop_ctrl_pkg::MC_RANGE_MAX) ? {1'b0, loop_ctrl_pkg::MC_RANGE_MAX} : {1'b0, r};
    mcLimit = (loop_ctrl_pkg::ONE_CYCLE << (sh + 5'h01)) - loop_ctrl_pkg::ONE_CYCLE;
  endfunction : mcLimit

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] refMeta;
  logic [1:0] fbMeta;
  logic [1:0] validMeta;
  logic       refS;
  logic       fbS;
  logic       refPrev;
  logic       fbPrev;
  logic       validS;

  always_ff @(posedge clk)
  begin
    refMeta   <= {refMeta[0], refClk};
    fbMeta    <= {fbMeta[0], fbClk};
    validMeta <= {validMeta[0], refValid};
    refPrev   <= refS;
    fbPrev    <= fbS;
  end
  assign refS   = refMeta[1];
  assign fbS    = fbMeta[1];
  assign validS = validMeta[1];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0] inputMode;
  logic [15:0] holdCfg;
  logic [15:0] bwCtrl;
  logic [4:0]  pullinBw;
  logic [4:0]  trackingBw;
  logic [2:0]  damping;
  logic [15:0] edgeCtrl;
  logic [15:0] mcCtrl;
  logic [1:0]  auxBw;
  logic [15:0] offsetReg;
  logic [18:0] avgFreq;
  logic [23:0] trackedPhase;
  loop_ctrl_pkg::mode_e mode;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      inputMode  <= 16'h0000;
      holdCfg    <= 16'h0000;
      bwCtrl     <= 16'h0080;
      pullinBw   <= loop_ctrl_pkg::BW_RESET;
      trackingBw <= loop_ctrl_pkg::BW_RESET;
      damping    <= loop_ctrl_pkg::DAMP_RESET;
      edgeCtrl   <= 16'h0000;
      mcCtrl     <= 16'h0000;
      auxBw      <= 2'h0;
      offsetReg  <= 16'h0000;
    end
    else if (regWr)
    begin
      case (regAddr)
        loop_ctrl_pkg::ADDR_INPUT_MODE:   inputMode  <= regWrData;
        loop_ctrl_pkg::ADDR_HOLDOVER_CFG: holdCfg    <= regWrData;
        loop_ctrl_pkg::ADDR_BW_CTRL:      bwCtrl     <= regWrData;
        loop_ctrl_pkg::ADDR_PULLIN_BW:    pullinBw   <= clampBw(regWrData[4:0]); // [R12]
        loop_ctrl_pkg::ADDR_TRACKING_BW:  trackingBw <= clampBw(regWrData[4:0]); // [R12]
        loop_ctrl_pkg::ADDR_DAMPING:
          if (regWrData[2:0] >= 3'h1 && regWrData[2:0] <= loop_ctrl_pkg::DAMP_COUNT)
            damping <= regWrData[2:0]; // [R13]
        loop_ctrl_pkg::ADDR_EDGE_CTRL:    edgeCtrl   <= regWrData;
        loop_ctrl_pkg::ADDR_MULTI_CYCLE:  mcCtrl     <= regWrData;
        loop_ctrl_pkg::ADDR_AUX_BW:
          if (regWrData[1:0] < loop_ctrl_pkg::AUX_BW_COUNT)
            auxBw <= regWrData[1:0]; // [R21]
        loop_ctrl_pkg::ADDR_PHASE_OFFSET:
          if (regWrData <= loop_ctrl_pkg::OFFSET_LIMIT || regWrData >= (16'h0000 - loop_ctrl_pkg::OFFSET_LIMIT))
            offsetReg <= regWrData; // [R22]
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      regRdData <= 16'h0000;
    else if (regRd)
    begin
      case (regAddr)
        loop_ctrl_pkg::ADDR_INPUT_MODE:   regRdData <= inputMode;
        loop_ctrl_pkg::ADDR_HOLDOVER_CFG: regRdData <= holdCfg;
        loop_ctrl_pkg::ADDR_BW_CTRL:      regRdData <= bwCtrl;
        loop_ctrl_pkg::ADDR_PULLIN_BW:    regRdData <= {11'h000, pullinBw};
        loop_ctrl_pkg::ADDR_TRACKING_BW:  regRdData <= {11'h000, trackingBw};
        loop_ctrl_pkg::ADDR_DAMPING:      regRdData <= {13'h0000, damping};
        loop_ctrl_pkg::ADDR_EDGE_CTRL:    regRdData <= edgeCtrl;
        loop_ctrl_pkg::ADDR_MULTI_CYCLE:  regRdData <= mcCtrl;
        loop_ctrl_pkg::ADDR_AUX_BW:       regRdData <= {14'h0000, auxBw};
        loop_ctrl_pkg::ADDR_PHASE_OFFSET: regRdData <= offsetReg;
        loop_ctrl_pkg::ADDR_STATUS:
          regRdData <= {8'h00, phaseAlarm, disqualify, nearestEdge, miniHoldover, 1'b0, operatingMode};
        loop_ctrl_pkg::ADDR_AVG_FREQ:     regRdData <= avgFreq[18:3]; // [R23]
        loop_ctrl_pkg::ADDR_TRACKED_PH:   regRdData <= trackedPhase[23:8]; // [R20]
        default:                          regRdData <= 16'h0000;
      endcase
    end
    else
      regRdData <= 16'h0000;
  end

  // ----------------------------------------------------------------------
  // Input loss detection and short freeze
  // ----------------------------------------------------------------------
  logic [15:0] refPeriod;
  logic [15:0] sinceEdge;
  logic        refEdge;
  logic        refStopped;
  logic        refSelPrev;

  assign refEdge = refS & ~refPrev;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sinceEdge <= 16'h0000;
      refPeriod <= 16'hFFFF;
    end
    else if (refEdge)
    begin
      refPeriod <= sinceEdge;
      sinceEdge <= 16'h0000;
    end
    else if (sinceEdge != 16'hFFFF)
      sinceEdge <= sinceEdge + 16'h0001; // [R09]
  end

  assign refStopped = (sinceEdge > {refPeriod[14:0], 1'b0}) || !validS; // [R01]

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      miniHoldover <= 1'b0;
      freezeFreq   <= 19'h00000;
      refSelPrev   <= 1'b0;
    end
    else
    begin
      refSelPrev <= refSelected;
      if (!miniHoldover && refStopped && (mode == loop_ctrl_pkg::ST_LOCKED
          || mode == loop_ctrl_pkg::ST_PRELOCK || mode == loop_ctrl_pkg::ST_REACQUIRE))
      begin
        miniHoldover <= 1'b1; // [R01]
        case (holdCfg[loop_ctrl_pkg::MINI_MODE_HI:loop_ctrl_pkg::MINI_MODE_LO]) // [R02]
          2'h0:    freezeFreq <= loopFreqIn;
          2'h1:    freezeFreq <= avgFreq;
          2'h2:    freezeFreq <= 19'h00000;
          default: freezeFreq <= freezeFreq;
        endcase
      end
      else if (miniHoldover && ((refSelected && !refSelPrev) || mode == loop_ctrl_pkg::ST_HOLDOVER
               || !refStopped))
        miniHoldover <= 1'b0; // [R03]
    end
  end

  // ----------------------------------------------------------------------
  // Lock qualification
  // ----------------------------------------------------------------------
  logic [31:0] lockCnt;
  logic        lockedQual;
  logic [1:0]  lockMeta;

  always_ff @(posedge clk)
  begin
    lockMeta <= {lockMeta[0], phaseLockRaw};
    if (!resetn)
    begin
      lockCnt    <= 32'h00000000;
      lockedQual <= 1'b0;
    end
    else if (!lockMeta[1])
    begin
      lockCnt    <= 32'h00000000;
      lockedQual <= 1'b0;
    end
    else if (lockCnt >= 32'(LOCK_CYCLES - 1))
      lockedQual <= 1'b1; // [R24]
    else
      lockCnt <= lockCnt + 32'h00000001;
  end

  // ----------------------------------------------------------------------
  // Mode machine
  // ----------------------------------------------------------------------
  logic [31:0] reacqCnt;
  logic        forceLock;
  logic        revertive;

  assign forceLock = inputMode[loop_ctrl_pkg::FORCE_LOCK_BIT]; // [R08]
  assign revertive = inputMode[loop_ctrl_pkg::REVERTIVE_BIT];

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      mode       <= loop_ctrl_pkg::ST_FREE_RUN;
      reacqCnt   <= 32'h00000000;
      disqualify <= 1'b0;
      phaseAlarm <= 1'b0;
    end
    else
    begin
      disqualify <= 1'b0;
      case (mode)
        loop_ctrl_pkg::ST_FREE_RUN:
          if (refSelected && validS)
            mode <= loop_ctrl_pkg::ST_PRELOCK;
        loop_ctrl_pkg::ST_PRELOCK:
          if (lockedQual || forceLock)
            mode <= loop_ctrl_pkg::ST_LOCKED;
          else if (!refSelected)
            mode <= loop_ctrl_pkg::ST_FREE_RUN;
        loop_ctrl_pkg::ST_LOCKED:
          if (!validS || !refSelected)
            mode <= loop_ctrl_pkg::ST_HOLDOVER;
          else if (revertive && higherPrioValid)
          begin
            mode     <= loop_ctrl_pkg::ST_REACQUIRE; // [R05]
            reacqCnt <= 32'h00000000;
          end
        loop_ctrl_pkg::ST_HOLDOVER:
          if (!disqualify && ((refSelected && validS) || (revertive && higherPrioValid)))
          begin
            mode       <= loop_ctrl_pkg::ST_REACQUIRE; // [R04] [R05]
            reacqCnt   <= 32'h00000000;
            phaseAlarm <= 1'b0;
          end
        loop_ctrl_pkg::ST_REACQUIRE:
          if (lockedQual || forceLock)
            mode <= loop_ctrl_pkg::ST_LOCKED; // [R06]
          else if (reacqCnt >= 32'(REACQ_CYCLES - 1))
          begin
            mode       <= loop_ctrl_pkg::ST_HOLDOVER; // [R07]
            disqualify <= 1'b1;
            phaseAlarm <= 1'b1;
          end
          else
            reacqCnt <= reacqCnt + 32'h00000001; // [R06]
        default:
          mode <= loop_ctrl_pkg::ST_FREE_RUN;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      operatingMode <= 3'h0;
    else
      operatingMode <= 3'(mode);
  end

  // ----------------------------------------------------------------------
  // Bandwidth, damping and auxiliary loop selection
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      activeBw   <= loop_ctrl_pkg::BW_RESET;
      dampingSel <= loop_ctrl_pkg::DAMP_RESET;
      auxBwSel   <= 2'h0;
    end
    else
    begin
      if (bwCtrl[loop_ctrl_pkg::AUTO_BW_BIT] && !lockedQual)
        activeBw <= pullinBw; // [R10] [R25] [R26]
      else
        activeBw <= trackingBw; // [R11] [R25]
      dampingSel <= damping; // [R13]
      auxBwSel   <= auxBw; // [R21]
    end
  end

  // ----------------------------------------------------------------------
  // Input division and phase detector
  // ----------------------------------------------------------------------
  logic        halfToggle;
  logic [15:0] divCnt;
  logic        divEdge;
  logic        eightKhz;

  assign eightKhz = inputMode[loop_ctrl_pkg::EIGHT_KHZ_BIT]; // [R15]

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      halfToggle <= 1'b0;
      divCnt     <= 16'h0000;
    end
    else if (refEdge)
    begin
      halfToggle <= ~halfToggle; // [R14]
      divCnt     <= (divCnt >= bwCtrl[15:0] >> 8) ? 16'h0000 : divCnt + 16'h0001;
    end
  end

  assign divEdge = refEdge && (eightKhz ? (divCnt == 16'h0000) // [R15]
                   : (!inputMode[loop_ctrl_pkg::DIV_155_BIT] || halfToggle)); // [R14]

  logic [23:0] sweep;
  logic [23:0] limit;
  logic        fbEdge;
  logic        mcOn;

  assign fbEdge = fbS & ~fbPrev;
  assign mcOn   = mcCtrl[loop_ctrl_pkg::MC_ENABLE_BIT]; // [R18]
  assign limit  = mcLimit(mcCtrl[3:0]); // [R18]

  always_ff @(posedge clk)
  begin
    if (!resetn)
      trackedPhase <= 24'h000000;
    else if (divEdge && !fbEdge && $signed(trackedPhase) < $signed(limit))
      trackedPhase <= trackedPhase + loop_ctrl_pkg::ONE_CYCLE; // [R20]
    else if (fbEdge && !divEdge && $signed(trackedPhase) > -$signed(limit))
      trackedPhase <= trackedPhase - loop_ctrl_pkg::ONE_CYCLE; // [R20]
  end

  assign sweep = (!mcOn || !mcCtrl[loop_ctrl_pkg::MC_IN_LOOP_BIT])
                 ? (($signed(trackedPhase) > $signed(loop_ctrl_pkg::ONE_CYCLE)) ? loop_ctrl_pkg::ONE_CYCLE
                 : ($signed(trackedPhase) < -$signed(loop_ctrl_pkg::ONE_CYCLE))
                   ? -loop_ctrl_pkg::ONE_CYCLE : trackedPhase) // [R19]
                 : trackedPhase; // [R19]

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      nearestEdge <= 1'b0;
      loopPhase   <= 24'h000000;
      phaseOffset <= 16'h0000;
    end
    else
    begin
      nearestEdge <= lockedQual && !mcOn && !edgeCtrl[loop_ctrl_pkg::NO_NEAREST_BIT]; // [R16] [R17]
      loopPhase   <= sweep;
      phaseOffset <= offsetReg; // [R22]
    end
  end

  // ----------------------------------------------------------------------
  // Holdover averager
  // ----------------------------------------------------------------------
  logic [18:0] avgStep;
  assign avgStep = holdCfg[loop_ctrl_pkg::FAST_AVG_BIT] // [R23]
                   ? 19'($signed(loopFreqIn - avgFreq) >>> 6)
                   : 19'($signed(loopFreqIn - avgFreq) >>> 10);

  always_ff @(posedge clk)
  begin
    if (!resetn)
      avgFreq <= 19'h00000;
    else if (mode == loop_ctrl_pkg::ST_LOCKED && divEdge)
      avgFreq <= avgFreq + avgStep; // [R23]
  end

endmodule : dpll_mode_and_phase_detect

`default_nettype wire

// [rtl/loop_ctrl_pkg.sv]
// Constants and types for the main timing loop mode and phase detect block.
package loop_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_INPUT_MODE   = 4'h0;
  localparam logic [3:0] ADDR_HOLDOVER_CFG = 4'h1;
  localparam logic [3:0] ADDR_BW_CTRL      = 4'h2;
  localparam logic [3:0] ADDR_PULLIN_BW    = 4'h3;
  localparam logic [3:0] ADDR_TRACKING_BW  = 4'h4;
  localparam logic [3:0] ADDR_DAMPING      = 4'h5;
  localparam logic [3:0] ADDR_EDGE_CTRL    = 4'h6;
  localparam logic [3:0] ADDR_MULTI_CYCLE  = 4'h7;
  localparam logic [3:0] ADDR_AUX_BW       = 4'h8;
  localparam logic [3:0] ADDR_PHASE_OFFSET = 4'h9;
  localparam logic [3:0] ADDR_STATUS       = 4'hA;
  localparam logic [3:0] ADDR_AVG_FREQ     = 4'hB;
  localparam logic [3:0] ADDR_TRACKED_PH   = 4'hC;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int MINI_MODE_LO     = 3;
  localparam int MINI_MODE_HI     = 4;
  localparam int FAST_AVG_BIT     = 6;
  localparam int AUTO_BW_BIT      = 7;
  localparam int EIGHT_KHZ_BIT    = 6;
  localparam int NO_NEAREST_BIT   = 6;
  localparam int MC_ENABLE_BIT    = 6;
  localparam int MC_IN_LOOP_BIT   = 5;
  localparam int REVERTIVE_BIT    = 0;
  localparam int FORCE_LOCK_BIT   = 1;
  localparam int DIV_155_BIT      = 2;

  // ----------------------------------------------------------------------
  // Ranges and reset values
  // ----------------------------------------------------------------------
  localparam logic [4:0] BW_STEPS      = 5'h12;
  localparam logic [2:0] DAMP_COUNT    = 3'h5;
  localparam logic [1:0] AUX_BW_COUNT  = 2'h3;
  localparam logic [4:0] BW_RESET      = 5'h08;
  localparam logic [2:0] DAMP_RESET    = 3'h3;
  localparam logic [3:0] MC_RANGE_MAX  = 4'hC;
  localparam logic [15:0] OFFSET_LIMIT = 16'h8236;
  localparam int FREQ_W                = 19;
  localparam int PHASE_W               = 24;
  localparam logic [PHASE_W-1:0] ONE_CYCLE = 24'h000100;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam longint CLK_HZ          = 20000000;
  localparam longint REACQ_LIMIT_S   = 100;
  localparam longint LOCK_HOLD_S     = 1;
  localparam longint REACQ_CYCLES    = REACQ_LIMIT_S * CLK_HZ;
  localparam longint LOCK_HOLD_CYCLES = LOCK_HOLD_S * CLK_HZ;
  localparam int     MISS_CYCLES_MAX = 2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_FREE_RUN,
    ST_PRELOCK,
    ST_LOCKED,
    ST_HOLDOVER,
    ST_REACQUIRE
  } mode_e;

endpackage : loop_ctrl_pkg

// [testbench/ref_source_model.sv]
// Reference and feedback clock source facing the main loop.
`timescale 1ns/1ns
`default_nettype none
module ref_source_model #(
  parameter int HALF = 3
) (
  input  wire logic clk,
  input  wire logic run,
  output logic      refClk,
  output logic      fbClk
);
  int count = 0;
  initial
  begin
    refClk = 1'b0;
    fbClk  = 1'b1;
  end
  // Both clocks stand still while run is low, so the loop sees a lost input.
  always @(posedge clk)
  begin
    if (run && count == HALF - 1)
    begin
      refClk <= !refClk;
      fbClk  <= refClk;
    end
    count <= (run && count < HALF - 1) ? count + 1 : 0;
  end
endmodule : ref_source_model
`default_nettype wire

// [testbench/dpll_mode_and_phase_detect_sva.sv]
// Checker for the main loop mode and phase detect block.
`timescale 1ns/1ns
`default_nettype none
module dpll_mode_and_phase_detect_sva #(
  parameter longint REACQ_CYCLES = 200
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  input wire logic        refSelected,
  input wire logic        miniHoldover,
  input wire logic [2:0]  operatingMode,
  input wire logic        disqualify,
  input wire logic        phaseAlarm,
  input wire logic [4:0]  activeBw,
  input wire logic [2:0]  dampingSel,
  input wire logic        nearestEdge
);
  logic   forced;
  longint reacqCount;
  always_ff @(posedge clk)
    if (!resetn) forced <= 1'b0;
    else if (regWr && regAddr == loop_ctrl_pkg::ADDR_INPUT_MODE)
      forced <= regWrData[loop_ctrl_pkg::FORCE_LOCK_BIT];
  always_ff @(posedge clk)
    if (!resetn || operatingMode != 3'h4) reacqCount <= 0;
    else reacqCount <= reacqCount + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_READ_IDLE: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data not zero outside a read");
  AST_DISQ_PULSE: assert property (disqualify |=> !disqualify)
    else $error("disqualify longer than one cycle");
  AST_DISQ_ALARM: assert property (disqualify |-> ##[0:2] phaseAlarm)
    else $error("no phase alarm after disqualify");
  AST_DISQ_HOLD: assert property (disqualify |-> ##[0:3] operatingMode == 3'h3)
    else $error("no return to holdover after disqualify");
  AST_REACQ_LIMIT: assert property (!forced |-> reacqCount <= REACQ_CYCLES + 4)
    else $error("reacquire state outlived its limit");
  AST_REACQ_SRC: assert property ($rose(operatingMode == 3'h4) |-> $past(refSelected, 2))
    else $error("reacquire entered without a selected source");
  AST_MINI_END: assert property ($rose(operatingMode == 3'h3) |-> ##[0:3] !miniHoldover)
    else $error("short freeze outlasted holdover entry");
  AST_NEAR_LOCK: assert property ($rose(nearestEdge) |-> ##[0:2] operatingMode == 3'h2)
    else $error("nearest edge capture while unlocked");
  AST_RESET_VAL: assert property ($rose(resetn) |-> activeBw == 5'h08 && dampingSel == 3'h3)
    else $error("wrong bandwidth or damping after reset");
  cover property (disqualify);
  cover property (miniHoldover);
  cover property (nearestEdge);
endmodule : dpll_mode_and_phase_detect_sva
bind dpll_mode_and_phase_detect dpll_mode_and_phase_detect_sva #(
  .REACQ_CYCLES(REACQ_CYCLES)
) sva (
  .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .refSelected(refSelected),
  .miniHoldover(miniHoldover), .operatingMode(operatingMode), .disqualify(disqualify),
  .phaseAlarm(phaseAlarm), .activeBw(activeBw), .dampingSel(dampingSel),
  .nearestEdge(nearestEdge)
);
`default_nettype wire

// [testbench/dpll_mode_and_phase_detect_bench.sv]
// Self-checking bench for the main loop mode and phase detect block.
`timescale 1ns/1ns
`default_nettype none
module dpll_mode_and_phase_detect_bench;
  logic        clk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0, run = 1'b0;
  logic        refValid = 1'b0, refSelected = 1'b0, higherPrioValid = 1'b0;
  logic        phaseLockRaw = 1'b0, refClk, fbClk, miniHoldover, disqualify;
  logic        phaseAlarm, nearestEdge;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000, regRdData, phaseOffset, v;
  logic [18:0] loopFreqIn = 19'h00000, freezeFreq;
  logic [2:0]  operatingMode, dampingSel;
  logic [1:0]  auxBwSel;
  logic [4:0]  activeBw;
  logic [23:0] loopPhase;
  int          errCount = 0, totalChecks = 0, cycles = 0, n, i, expDamp = 3, expAux = 0;
  int          expPull, expTrack;
  integer      seed;
  dpll_mode_and_phase_detect #(.REACQ_CYCLES(200), .LOCK_CYCLES(20)) DUT (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .refClk(refClk), .fbClk(fbClk),
    .refValid(refValid), .refSelected(refSelected), .higherPrioValid(higherPrioValid),
    .phaseLockRaw(phaseLockRaw), .loopFreqIn(loopFreqIn), .miniHoldover(miniHoldover),
    .operatingMode(operatingMode), .disqualify(disqualify), .phaseAlarm(phaseAlarm),
    .activeBw(activeBw), .dampingSel(dampingSel), .auxBwSel(auxBwSel),
    .nearestEdge(nearestEdge), .loopPhase(loopPhase), .freezeFreq(freezeFreq),
    .phaseOffset(phaseOffset));
  ref_source_model #(.HALF(3)) source (.clk(clk), .run(run), .refClk(refClk), .fbClk(fbClk));
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errCount++;
      finalReport();
    end
  end
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    d = regRdData;
  endtask : rd
  task automatic waitMode(input logic [2:0] m, input int limit);
    n = 0;
    while (operatingMode !== m && n < limit)
    begin
      @(posedge clk);
      n++;
    end
    check("operatingMode", operatingMode, m);
  endtask : waitMode
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  task automatic finalReport;
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finalReport
  initial
  begin
    seed = 32'hE9C0;
    tick(6);
    resetn <= 1'b1;
    tick(1);
    check("activeBw", activeBw, 5'h08);
    check("dampingSel", dampingSel, 3'h3);
    for (i = 0; i < 12; i++)
    begin
      v = 16'($random(seed));
      wr(loop_ctrl_pkg::ADDR_DAMPING, {13'h0000, v[2:0]});
      wr(loop_ctrl_pkg::ADDR_AUX_BW, {14'h0000, v[5:4]});
      wr(loop_ctrl_pkg::ADDR_PHASE_OFFSET, v);
      if (v[2:0] >= 1 && v[2:0] <= 5) expDamp = v[2:0];
      if (v[5:4] <= 2) expAux = v[5:4];
      tick(2);
      check("dampingSel", dampingSel, expDamp[2:0]);
      check("auxBwSel", auxBwSel, expAux[1:0]);
      check("phaseOffset", phaseOffset, v);
    end
    v = 16'($random(seed));
    expPull = 17;
    expTrack = v[3:0];
    wr(loop_ctrl_pkg::ADDR_PULLIN_BW, 16'h001F);
    wr(loop_ctrl_pkg::ADDR_TRACKING_BW, {12'h000, v[3:0]});
    tick(3);
    check("activeBw", activeBw, expPull[4:0]);
    wr(loop_ctrl_pkg::ADDR_BW_CTRL, 16'h0000);
    tick(3);
    check("activeBw", activeBw, expTrack[4:0]);
    wr(loop_ctrl_pkg::ADDR_BW_CTRL, 16'h0080);
    rd(4'hF, v);
    check("unmapped", v, 16'h0000);
    wr(loop_ctrl_pkg::ADDR_HOLDOVER_CFG, 16'h0000);
    loopFreqIn <= 19'($random(seed));
    run <= 1'b1;
    refValid <= 1'b1;
    refSelected <= 1'b1;
    phaseLockRaw <= 1'b1;
    waitMode(3'h2, 150);
    check("lockDelay", n >= 20, 1'b1);
    tick(3);
    check("activeBw", activeBw, expTrack[4:0]);
    check("nearestEdge", nearestEdge, 1'b1);
    rd(loop_ctrl_pkg::ADDR_STATUS, v);
    check("statusMode", v[2:0], 3'h2);
    wr(loop_ctrl_pkg::ADDR_EDGE_CTRL, 16'h0040);
    tick(3);
    check("nearestEdge", nearestEdge, 1'b0);
    run <= 1'b0;
    for (n = 0; n < 40 && miniHoldover !== 1'b1; n++) tick(1);
    check("miniHoldover", miniHoldover, 1'b1);
    check("freezeFreq", freezeFreq, loopFreqIn);
    refValid <= 1'b0;
    refSelected <= 1'b0;
    waitMode(3'h3, 40);
    tick(4);
    check("miniHoldover", miniHoldover, 1'b0);
    phaseLockRaw <= 1'b0;
    run <= 1'b1;
    refValid <= 1'b1;
    refSelected <= 1'b1;
    waitMode(3'h4, 40);
    for (n = 0; n < 400 && disqualify !== 1'b1; n++) tick(1);
    check("disqualify", disqualify, 1'b1);
    check("reacqTime", n >= 190 && n <= 210, 1'b1);
    refSelected <= 1'b0;
    tick(2);
    check("phaseAlarm", phaseAlarm, 1'b1);
    waitMode(3'h3, 10);
    wr(loop_ctrl_pkg::ADDR_INPUT_MODE, 16'h0002);
    refSelected <= 1'b1;
    // Software holds the loop locked through a long acquisition.
    n = 0;
    repeat (400)
    begin
      @(posedge clk);
      if (disqualify === 1'b1) n++;
    end
    check("forcedDisq", n, 0);
    finalReport();
  end
endmodule : dpll_mode_and_phase_detect_bench
`default_nettype wire
